// file: src/plrfm_regs.vh
/*
 * constants of the power loss recovery and fan monitor block: policy codes,
 * watchdog stage actions and timing counts at a 250 MHz sys_clk.
 * assumes it is included by bare name from the design files.
 */
`ifndef PLRFM_REGS_VH
`define PLRFM_REGS_VH

// ============================================================
// clock and timing
`define PLRFM_CLK_MHZ          250
`define PLRFM_WINDOW_SEC       30
// 7.5e9 cycles does not fit 32 bits, so the product is formed at 64 bits
`define PLRFM_WINDOW_CYC       (`PLRFM_WINDOW_SEC * `PLRFM_CLK_MHZ * 64'd1000000)
`define PLRFM_GATE_MS          1000
`define PLRFM_GATE_CYC         (`PLRFM_GATE_MS * `PLRFM_CLK_MHZ * 1000)
`define PLRFM_PULSES_PER_REV   2
`define PLRFM_SEC_PER_MIN      60

// ============================================================
// recovery policy codes
`define PLRFM_POL_TURN_ON      2'h0
`define PLRFM_POL_REMAIN_OFF   2'h1
`define PLRFM_POL_LAST_STATE   2'h2

// ============================================================
// watchdog stage actions (no nmi code exists)
`define PLRFM_WD_ACT_DISABLED  2'h0
`define PLRFM_WD_ACT_EVENT     2'h1
`define PLRFM_WD_ACT_RESET     2'h2
`define PLRFM_WD_ACT_PWRBTN    2'h3

// ============================================================
// reset values
`define PLRFM_RST_PWM_DUTY     8'h80
`define PLRFM_RST_LAST_STATE   1'b0

`endif

// file: src/plrfm_fan_tach.v
/*
 * fan speed monitor: counts rising edges of the tach input over a gate
 * interval and reports revolutions per minute.
 * assumes fan_speed_sense_in is synchronous to sys_clk.
 */
`include "plrfm_regs.vh"

module plrfm_fan_tach #(
    parameter GATE_CYC = `PLRFM_GATE_CYC
) (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire        clk_en,
    input  wire        fan_speed_sense_in,
    output reg  [15:0] fan_rpm,
    output reg         rpm_valid
);

    reg [31:0] gate_cnt;
    reg [15:0] edge_cnt;
    reg        tach_prev;
    wire       tach_rise = fan_speed_sense_in & ~tach_prev;
    wire [15:0] edge_total = edge_cnt + {15'h0000, tach_rise};
    // rpm = edges / pulses per rev * (60 s / gate seconds)
    wire [31:0] rpm_full = ({16'h0000, edge_total} * `PLRFM_SEC_PER_MIN * 1000)
                           / (`PLRFM_PULSES_PER_REV * `PLRFM_GATE_MS);

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            gate_cnt  <= 32'h0000_0000;
            edge_cnt  <= 16'h0000;
            tach_prev <= 1'b0;
            fan_rpm   <= 16'h0000;
            rpm_valid <= 1'b0;
        end else if (clk_en) begin
            tach_prev <= fan_speed_sense_in;
            if (gate_cnt == GATE_CYC - 1) begin
                gate_cnt  <= 32'h0000_0000;
                edge_cnt  <= 16'h0000;
                fan_rpm   <= rpm_full[15:0];
                rpm_valid <= 1'b1;
            end else begin
                gate_cnt <= gate_cnt + 32'h0000_0001;
                if (tach_rise && edge_cnt != 16'hFFFF) begin
                    edge_cnt <= edge_cnt + 16'h0001;
                end
            end
        end
    end

endmodule // plrfm_fan_tach

// file: src/plrfm_top.v
/*
 * power loss recovery, fan drive and multi-stage watchdog of the board
 * controller.
 * assumes all inputs are synchronous to sys_clk and sys_rst is power-on reset.
 */
// Functional notes
// - after shutdown or power loss, standby rail is sampled continuously
// - standby good for full 30 s window means orderly switch-off
// - standby lost inside 30 s window means mains power loss
// - three recovery policies on standby return: turn on, remain off, last state
// - last state policy restores on/off state held before loss
// - the 30 s window runs only under last state policy
// - loss within 30 s of shutdown may record prior state as on
// - without a standby rail the policy has no effect
// - fan speed set by pwm output duty cycle
// - fan gives two tach pulses per revolution, counted for rpm
// - software-triggered multi-stage watchdog, no nmi stage action
`include "plrfm_regs.vh"

module plrfm_top #(
    parameter WINDOW_CYC = `PLRFM_WINDOW_CYC,
    parameter GATE_CYC   = `PLRFM_GATE_CYC
) (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire        clk_en,
    input  wire        standby_good,
    input  wire        standby_supported,
    input  wire        system_on,
    input  wire [1:0]  recovery_policy,
    input  wire [7:0]  fan_duty,
    input  wire        fan_speed_sense_in,
    input  wire        wd_enable,
    input  wire        wd_trigger,
    input  wire [31:0] wd_stage1_cyc,
    input  wire [31:0] wd_stage2_cyc,
    input  wire [1:0]  wd_stage1_act,
    input  wire [1:0]  wd_stage2_act,
    output reg         power_on_req,
    output reg         mains_loss_seen,
    output reg         orderly_off_seen,
    output reg         last_state_on,
    output reg         fan_speed_drive_out,
    output reg  [15:0] fan_rpm,
    output reg         rpm_valid,
    output reg         wd_event,
    output reg         wd_reset_req,
    output reg         wd_pwrbtn_req,
    output reg  [1:0]  wd_stage
);

    // ============================================================
    // power loss classification
    localparam ST_RUN    = 2'h0;
    localparam ST_WATCH  = 2'h1;
    localparam ST_OFF    = 2'h2;
    localparam ST_LOST   = 2'h3;

    reg [1:0]  pl_state;
    reg [32:0] win_cnt;
    reg        sys_on_prev;
    reg        stby_prev;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            pl_state         <= ST_OFF;
            win_cnt          <= 33'h0_0000_0000;
            sys_on_prev      <= 1'b0;
            stby_prev        <= 1'b0;
            power_on_req     <= 1'b0;
            mains_loss_seen  <= 1'b0;
            orderly_off_seen <= 1'b0;
            last_state_on    <= `PLRFM_RST_LAST_STATE;
        end else if (clk_en) begin
            sys_on_prev  <= system_on;
            stby_prev    <= standby_good;
            power_on_req <= 1'b0;
            case (pl_state)
                ST_RUN: begin
                    // the running state is what last state restores
                    last_state_on <= 1'b1;
                    if (!standby_good) begin
                        pl_state        <= ST_LOST;
                        mains_loss_seen <= 1'b1;
                    end else if (sys_on_prev && !system_on) begin
                        orderly_off_seen <= 1'b0;
                        mains_loss_seen  <= 1'b0;
                        win_cnt          <= 33'h0_0000_0000;
                        if (recovery_policy == `PLRFM_POL_LAST_STATE) begin
                            pl_state <= ST_WATCH;
                        end else begin
                            pl_state         <= ST_OFF;
                            orderly_off_seen <= 1'b1;
                        end
                    end
                end
                ST_WATCH: begin
                    // last state still reads on during the window
                    if (!standby_good) begin
                        pl_state        <= ST_LOST;
                        mains_loss_seen <= 1'b1;
                    end else if (system_on) begin
                        // power back on inside the window: no off verdict
                        pl_state <= ST_RUN;
                    end else if (win_cnt == WINDOW_CYC - 1) begin
                        pl_state         <= ST_OFF;
                        orderly_off_seen <= 1'b1;
                        last_state_on    <= 1'b0;
                    end else begin
                        win_cnt <= win_cnt + 33'h0_0000_0001;
                    end
                end
                ST_OFF: begin
                    if (!standby_good) begin
                        pl_state        <= ST_LOST;
                        mains_loss_seen <= 1'b1;
                    end else if (system_on) begin
                        pl_state <= ST_RUN;
                    end
                end
                default: begin
                    // standby returns after a mains loss
                    if (standby_good && !stby_prev && standby_supported) begin
                        if (recovery_policy == `PLRFM_POL_TURN_ON) begin
                            power_on_req <= 1'b1;
                        end else if (recovery_policy == `PLRFM_POL_LAST_STATE) begin
                            power_on_req <= last_state_on;
                        end
                        pl_state <= ST_OFF;
                    end else if (standby_good && !standby_supported) begin
                        pl_state <= ST_OFF;
                    end
                end
            endcase
        end
    end

    // ============================================================
    // fan pwm
    reg [7:0] pwm_cnt;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            pwm_cnt             <= 8'h00;
            fan_speed_drive_out <= 1'b0;
        end else if (clk_en) begin
            pwm_cnt             <= pwm_cnt + 8'h01;
            fan_speed_drive_out <= (pwm_cnt < fan_duty);
        end
    end

    // ============================================================
    // fan speed monitor
    wire [15:0] tach_rpm;
    wire        tach_valid;

    plrfm_fan_tach #(
        .GATE_CYC (GATE_CYC)
    ) u_tach (
        .sys_clk            (sys_clk),
        .sys_rst            (sys_rst),
        .clk_en             (clk_en),
        .fan_speed_sense_in (fan_speed_sense_in),
        .fan_rpm            (tach_rpm),
        .rpm_valid          (tach_valid)
    );

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            fan_rpm   <= 16'h0000;
            rpm_valid <= 1'b0;
        end else if (clk_en) begin
            fan_rpm   <= tach_rpm;
            rpm_valid <= tach_valid;
        end
    end

    // ============================================================
    // multi-stage watchdog
    reg [31:0] wd_cnt;
    reg [1:0]  act_now;
    wire [31:0] stage_lim = (wd_stage == 2'h1) ? wd_stage1_cyc : wd_stage2_cyc;

    always @* begin
        act_now = (wd_stage == 2'h1) ? wd_stage1_act : wd_stage2_act;
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            wd_cnt        <= 32'h0000_0000;
            wd_stage      <= 2'h0;
            wd_event      <= 1'b0;
            wd_reset_req  <= 1'b0;
            wd_pwrbtn_req <= 1'b0;
        end else if (clk_en) begin
            wd_event      <= 1'b0;
            wd_reset_req  <= 1'b0;
            wd_pwrbtn_req <= 1'b0;
            if (!wd_enable) begin
                wd_stage <= 2'h0;
                wd_cnt   <= 32'h0000_0000;
            end else if (wd_trigger || wd_stage == 2'h0) begin
                wd_stage <= 2'h1;
                wd_cnt   <= 32'h0000_0000;
            end else if (wd_stage != 2'h3) begin
                if (wd_cnt >= stage_lim) begin
                    wd_cnt   <= 32'h0000_0000;
                    wd_stage <= wd_stage + 2'h1;
                    // only event, reset and power button actions exist
                    if (act_now == `PLRFM_WD_ACT_EVENT) begin
                        wd_event <= 1'b1;
                    end else if (act_now == `PLRFM_WD_ACT_RESET) begin
                        wd_reset_req <= 1'b1;
                    end else if (act_now == `PLRFM_WD_ACT_PWRBTN) begin
                        wd_pwrbtn_req <= 1'b1;
                    end
                end else begin
                    wd_cnt <= wd_cnt + 32'h0000_0001;
                end
            end
        end
    end

endmodule // plrfm_top

// file: tb/plrfm_top_props.sv
/*
 * port checker of the recovery, fan drive and watchdog block.
 * assumes it is bound to plrfm_top, one sys_clk domain.
 */
module plrfm_props (
    input wire       sys_clk,
    input wire       sys_rst,
    input wire       standby_good,
    input wire       standby_supported,
    input wire       system_on,
    input wire [1:0] recovery_policy,
    input wire [1:0] wd_stage1_act,
    input wire [1:0] wd_stage2_act,
    input wire       power_on_req,
    input wire       mains_loss_seen,
    input wire       orderly_off_seen,
    input wire       rpm_valid,
    input wire       wd_event,
    input wire       wd_reset_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ============================================================
    // properties
    chk_reset_clears_flags: assert property ($fell(sys_rst) |->
        !power_on_req && !mains_loss_seen && !orderly_off_seen) else $error("flags after reset");
    chk_loss_needs_drop: assert property ($rose(mains_loss_seen) |->
        !$past(standby_good)) else $error("loss flag without standby drop");
    chk_off_needs_rail: assert property ($rose(orderly_off_seen) |->
        $past(standby_good) && !$past(system_on)) else $error("orderly off without standby");
    chk_remain_off_quiet: assert property (power_on_req |->
        $past(recovery_policy) != 2'h1) else $error("power request under remain off");
    chk_at_supply_quiet: assert property (power_on_req |->
        $past(standby_supported)) else $error("power request without standby rail");
    chk_power_pulse_once: assert property (power_on_req |=> !power_on_req)
        else $error("power request longer than one cycle");
    chk_wd_event_cause: assert property (wd_event |->
        ($past(wd_stage1_act) == 2'h1 || $past(wd_stage2_act) == 2'h1))
        else $error("watchdog event without event action");
    chk_wd_reset_once: assert property (wd_reset_req |=> !wd_reset_req)
        else $error("watchdog reset request too long");
    chk_rpm_valid_holds: assert property (rpm_valid |=> rpm_valid)
        else $error("rpm valid dropped");
endmodule // plrfm_props

bind plrfm_top plrfm_props u_props (.sys_clk, .sys_rst, .standby_good, .standby_supported,
    .system_on, .recovery_policy, .wd_stage1_act, .wd_stage2_act, .power_on_req,
    .mains_loss_seen, .orderly_off_seen, .rpm_valid, .wd_event, .wd_reset_req);

// file: tb/plrfm_far_side.sv
/*
 * model of the atx supply standby rail and a two pulse per turn fan.
 * assumes the bench drives ac_on and tach_per just after a rising edge.
 */
module plrfm_far_side (
    input  wire        sys_clk,
    input  wire        ac_on,
    input  wire [7:0]  tach_per,
    output logic       standby_good,
    output logic       fan_speed_sense_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    initial standby_good = 1'b1;
    initial fan_speed_sense_in = 1'b0;
    // ============================================================
    // one tach pulse every tach_per cycles, half a turn each; stands low at zero
    always @(posedge sys_clk) begin
        standby_good <= ac_on;
        cnt <= (cnt + 8'h01 >= tach_per) ? 8'h00 : cnt + 8'h01;
        fan_speed_sense_in <= (tach_per != 8'h00) && (cnt < tach_per / 2);
    end
endmodule // plrfm_far_side

// file: tb/plrfm_top_test.sv
/*
 * self-checking bench of plrfm_top with short window and gate counts.
 * assumes plrfm_far_side drives standby and tach, plrfm_props is bound.
 */
`define CHK(nm, e, a) chk(nm, e, a)
module plrfm_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WIN = 1000;
    localparam int GATE = 500;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, ac_on = 1'b1;
    logic        standby_supported = 1'b1, system_on = 1'b1, wd_enable = 1'b0;
    logic        wd_trigger = 1'b0, standby_good, fan_speed_sense_in, power_on_req;
    logic        mains_loss_seen, orderly_off_seen, last_state_on, fan_speed_drive_out;
    logic        rpm_valid, wd_event, wd_reset_req, wd_pwrbtn_req;
    logic [1:0]  recovery_policy = 2'h0, wd_stage1_act = 2'h0, wd_stage2_act = 2'h0, wd_stage;
    logic [7:0]  fan_duty = 8'h00, tach_per = 8'h00;
    logic [31:0] wd_stage1_cyc = 32'h0000_0014, wd_stage2_cyc = 32'h0000_03e8;
    logic [15:0] fan_rpm, hi, exp_rpm;
    logic [3:0]  exp_c;
    logic [3:0]  exp_q[$];
    int          fails = 0, n_tests = 0;

    plrfm_top #(.WINDOW_CYC(WIN), .GATE_CYC(GATE)) u_dut (.sys_clk, .sys_rst, .clk_en,
        .standby_good, .standby_supported, .system_on, .recovery_policy, .fan_duty,
        .fan_speed_sense_in, .wd_enable, .wd_trigger, .wd_stage1_cyc, .wd_stage2_cyc,
        .wd_stage1_act, .wd_stage2_act, .power_on_req, .mains_loss_seen, .orderly_off_seen,
        .last_state_on, .fan_speed_drive_out, .fan_rpm, .rpm_valid, .wd_event,
        .wd_reset_req, .wd_pwrbtn_req, .wd_stage);
    plrfm_far_side u_far (.sys_clk, .ac_on, .tach_per, .standby_good, .fan_speed_sense_in);

    // ============================================================
    // helpers
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] a);
        n_tests++;
        if (a !== e) begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", nm, e, a);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic done(input string nm);
        `CHK("pending pulses", 16'h0000, 16'(exp_q.size()));
        $display("end of %s test", nm);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ============================================================
    // clock, watchdog and pulse monitor
    initial forever #2 sys_clk = ~sys_clk;
    initial begin
        tick(30000);
        fails++;
        report_and_stop();
    end
    always @(negedge sys_clk) begin
        if (!sys_rst && {power_on_req, wd_event, wd_reset_req, wd_pwrbtn_req} !== 4'h0) begin
            exp_c = (exp_q.size() > 0) ? exp_q.pop_front() : 4'h0;
            `CHK("pulse code", exp_c, {power_on_req, wd_event, wd_reset_req, wd_pwrbtn_req});
        end
    end
    // ============================================================
    // tests
    initial begin
        void'($urandom(10571));
        tick(5);
        sys_rst = 1'b0;
        tick(20);
        for (int p = 0; p < 3; p++) begin
            recovery_policy = p[1:0];
            system_on = 1'b0;
            tick(10);
            `CHK("orderly early", p != 2, orderly_off_seen);
            ac_on = 1'b0;
            tick(3);
            `CHK("loss seen", 16'h0001, mains_loss_seen);
            if (p != 1)
                exp_q.push_back(4'h8);
            ac_on = 1'b1;
            tick(5);
            system_on = 1'b1;
            tick(5);
        end
        done("mains loss");
        system_on = 1'b0;
        tick(WIN - 20);
        `CHK("window open", 16'h0000, orderly_off_seen);
        tick(40);
        `CHK("window done", 16'h0001, orderly_off_seen);
        `CHK("last state", 16'h0000, last_state_on);
        ac_on = 1'b0;
        tick(3);
        ac_on = 1'b1;
        tick(5);
        done("orderly off");
        recovery_policy = 2'h0;
        standby_supported = 1'b0;
        system_on = 1'b1;
        tick(5);
        system_on = 1'b0;
        ac_on = 1'b0;
        tick(5);
        ac_on = 1'b1;
        tick(5);
        standby_supported = 1'b1;
        done("at supply");
        for (int i = 0; i < 3; i++) begin
            tach_per = 8'($urandom_range(4, 40));
            fan_duty = 8'($urandom_range(1, 254));
            tick(2 * GATE + 4);
            exp_rpm = 16'((GATE / tach_per) * 30);
            `CHK("rpm band", 16'h0001, fan_rpm + 16'd30 >= exp_rpm && fan_rpm <= exp_rpm + 16'd30);
            `CHK("rpm valid", 16'h0001, rpm_valid);
            hi = 16'h0000;
            repeat (256) begin
                tick(1);
                hi = hi + 16'(fan_speed_drive_out);
            end
            `CHK("pwm high cycles", 16'(fan_duty), hi);
        end
        hi = 16'(fan_speed_drive_out);
        clk_en = 1'b0;
        repeat (20) begin
            tick(1);
            `CHK("frozen pwm", hi, 16'(fan_speed_drive_out));
        end
        clk_en = 1'b1;
        done("fan");
        for (int a = 0; a < 4; a++) begin
            wd_stage1_act = a[1:0];
            wd_enable = 1'b1;
            repeat (3) begin
                tick(10);
                wd_trigger = 1'b1;
                tick(1);
                wd_trigger = 1'b0;
            end
            if (a != 0)
                exp_q.push_back(4'h8 >> a);
            tick(30);
            `CHK("wd stage", 16'h0002, wd_stage);
            wd_enable = 1'b0;
            tick(3);
        end
        done("watchdog");
        report_and_stop();
    end
endmodule // plrfm_top_test
